// >>> src/eiq_top.v
// Event input qualification, PWM trip and conversion-start strobes
// Function
// - Period field 0 bypasses; 0xFF spans 510.
// - Sample every 2n system clocks.
// - Six samples over five windows.
// - Level changes only when six agree; in bypass, when two agree.
// - Qualification time is five sampling periods.
// - Protect low tri-states its manager's PWM quickly.
// - Trip low tri-states related PWM outputs.
// - Interrupt edge fetches vector within bound.
// - After protect release, enable bit decides.
// - First conversion strobe low, 32 fast clocks.
// - Second conversion strobe low, 32 fast clocks.
`timescale 1ns/1ps
`include "eiq_regs.vh"
module eiq_top (
  // Clock and reset
  input  wire                    clk,
  input  wire                    resetn,
  // Qualification control
  input  wire [7:0]              qual_period_field,
  // Event inputs: [1:0] dir, [3:2] capture, [5:4] ext clk, [7:6] irq
  input  wire [1:0]              timer_dir_in,
  input  wire [1:0]              capture_in,
  input  wire [1:0]              timer_ext_clk_in,
  input  wire [1:0]              ext_irq_in,
  input  wire [1:0]              power_drive_protect_in,
  input  wire [5:0]              compare_trip_in,
  input  wire [3:0]              timer_compare_trip_in,
  // Output enables: bit 0 first manager, bit 1 second
  input  wire [1:0]              full_compare_out_enable,
  // Conversion requests, one-cycle pulses
  input  wire                    soc_req_first,
  input  wire                    soc_req_second,
  // Qualified levels
  output reg  [1:0]              timer_dir_q,
  output reg  [1:0]              capture_q,
  output reg  [1:0]              timer_ext_clk_q,
  // PWM drive enables: [5:0] first compare, [11:6] second, [15:12] timers
  output reg  [15:0]             pwm_oe,
  // Interrupt vector fetch request, one-cycle pulse per edge
  output reg  [1:0]              irq_fetch,
  // Conversion-start strobes, active low
  output reg                     ev_first_conv_start_out_n,
  output reg                     ev_second_conv_start_out_n
);
  reg  [8:0]  div_reg;
  reg         stb_reg;
  wire        bypass;
  wire [19:0] raw;
  wire [19:0] q;
  reg  [1:0]  irq_prev_reg;
  reg  [1:0]  pdp_hold_reg;
  reg  [7:0]  soc1_cnt_reg;
  reg  [7:0]  soc2_cnt_reg;
  reg  [15:0] pwm_oe_next;
  integer     k;
  integer     j;

  // Sampler step and strobe low-time reload value
  localparam [8:0]  ONE9     = 9'h001;
  localparam [31:0] SOC_LOAD = `EIQ_SOC_CYC - 1;

  // Clear or set every drive enable owned by one manager
  function [15:0] mgr_set;
    input [15:0] v;
    input        m;
    input        on;
    reg   [15:0] r;
    begin
      r = v;
      if (m) begin
        r[11:6]  = {6{on}};
        r[15:14] = {2{on}};
      end else begin
        r[5:0]   = {6{on}};
        r[13:12] = {2{on}};
      end
      mgr_set = r;
    end
  endfunction

  assign bypass = (qual_period_field == 8'h00);
  assign raw = {timer_compare_trip_in, compare_trip_in, power_drive_protect_in,
                ext_irq_in, timer_ext_clk_in, capture_in, timer_dir_in};

  // Sample strobe every 2n clocks, up to 510 at 0xFF
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= 9'h000;
      stb_reg <= 1'b0;
    end else if (bypass) begin
      div_reg <= 9'h000;
      stb_reg <= 1'b0;
    end else if (div_reg >= {qual_period_field, 1'b0} - ONE9) begin
      div_reg <= 9'h000;
      stb_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + ONE9;
      stb_reg <= 1'b0;
    end
  end

  // One qualifier per event input
  genvar g;
  generate
    for (g = 0; g < `EIQ_N_IN; g = g + 1) begin : g_q
      eiq_qualifier u_q (
        .clk        (clk),
        .resetn     (resetn),
        .sample_stb (stb_reg),
        .bypass     (bypass),
        .pin_in     (raw[g]),
        .level_reg  (q[g])
      );
    end
  endgenerate

  // Qualified levels and interrupt edge pulses
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_dir_q     <= 2'h3;
      capture_q       <= 2'h3;
      timer_ext_clk_q <= 2'h3;
      irq_prev_reg    <= 2'h3;
      irq_fetch       <= 2'h0;
    end else begin
      timer_dir_q     <= q[1:0];
      capture_q       <= q[3:2];
      timer_ext_clk_q <= q[5:4];
      irq_prev_reg    <= q[7:6];
      irq_fetch       <= q[7:6] ^ irq_prev_reg;
    end
  end

  // PWM enables: protect and trips drop drive; release waits on enable bit
  always @* begin
    pwm_oe_next = pwm_oe;
    // Enable bit restores drive unless a protect event is latched
    for (k = 0; k < 2; k = k + 1) begin
      if (!full_compare_out_enable[k])
        pwm_oe_next = mgr_set(pwm_oe_next, k[0], 1'b0);
      else if (!pdp_hold_reg[k])
        pwm_oe_next = mgr_set(pwm_oe_next, k[0], 1'b1);
    end
    // Compare trip k drops its output pair
    for (k = 0; k < `EIQ_N_CTRIP; k = k + 1) begin
      if (!q[10 + k])
        pwm_oe_next[2*k +: 2] = 2'h0;
    end
    // Timer trip k drops its own timer output
    for (k = 0; k < `EIQ_N_TTRIP; k = k + 1) begin
      if (!q[16 + k])
        pwm_oe_next[12 + k] = 1'b0;
    end
    // Protect drops every output of its manager
    for (k = 0; k < 2; k = k + 1) begin
      if (!q[8 + k])
        pwm_oe_next = mgr_set(pwm_oe_next, k[0], 1'b0);
    end
  end

  // Protect latch: cleared only by software disabling output enable
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pdp_hold_reg <= 2'h0;
      pwm_oe       <= 16'h0000;
    end else begin
      // A new protect event wins over a clear in the same cycle
      for (j = 0; j < 2; j = j + 1) begin
        if (!q[8 + j])
          pdp_hold_reg[j] <= 1'b1;
        else if (!full_compare_out_enable[j])
          pdp_hold_reg[j] <= 1'b0;
      end
      pwm_oe <= pwm_oe_next;
    end
  end

  // Conversion-start strobes: low next edge, held for 32 fast clock periods
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      soc1_cnt_reg               <= 8'h00;
      soc2_cnt_reg               <= 8'h00;
      ev_first_conv_start_out_n  <= 1'b1;
      ev_second_conv_start_out_n <= 1'b1;
    end else begin
      if (soc_req_first) begin
        soc1_cnt_reg              <= SOC_LOAD[7:0];
        ev_first_conv_start_out_n <= 1'b0;
      end else if (soc1_cnt_reg != 8'h00) begin
        soc1_cnt_reg <= soc1_cnt_reg - 8'h01;
      end else begin
        ev_first_conv_start_out_n <= 1'b1;
      end
      if (soc_req_second) begin
        soc2_cnt_reg               <= SOC_LOAD[7:0];
        ev_second_conv_start_out_n <= 1'b0;
      end else if (soc2_cnt_reg != 8'h00) begin
        soc2_cnt_reg <= soc2_cnt_reg - 8'h01;
      end else begin
        ev_second_conv_start_out_n <= 1'b1;
      end
    end
  end
endmodule

// >>> include/eiq_regs.vh
// Constants for the event input qualifier and trip block
`ifndef EIQ_REGS_VH
`define EIQ_REGS_VH
`define EIQ_QUAL_W        8
`define EIQ_QUAL_MAX      8'h00_FF
`define EIQ_SAMPLES       6
`define EIQ_HIST_W        3
`define EIQ_DIV_W         9
`define EIQ_CLK_NS        8
`define EIQ_HS_PERIOD_NS  8
`define EIQ_SOC_HS_PER    32
`define EIQ_SOC_NS        (`EIQ_SOC_HS_PER * `EIQ_HS_PERIOD_NS)
`define EIQ_SOC_CYC       ((`EIQ_SOC_NS + `EIQ_CLK_NS - 1) / `EIQ_CLK_NS)
`define EIQ_SOC_CNT_W     8
`define EIQ_N_IN          20
`define EIQ_N_CTRIP       6
`define EIQ_N_TTRIP       4
`define EIQ_N_PWM         16
`define EIQ_IRQ_LAT       12
`endif

// >>> src/eiq_qualifier.v
// Per-input three-flop synchroniser and six-sample level qualifier
`timescale 1ns/1ps
module eiq_qualifier (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Sample strobe and bypass
  input  wire       sample_stb,
  input  wire       bypass,
  // Raw pin and qualified level
  input  wire       pin_in,
  output reg        level_reg
);
  reg       s1_reg;
  reg       s2_reg;
  reg       s3_reg;
  reg [4:0] hist_reg;
  wire      stable;

  // Pin enters through three flops; in bypass a change counts once the last two agree
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Five stored samples plus the current one make six
  assign stable = (s2_reg == s3_reg) &&
                  (hist_reg == {5{s3_reg}});

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hist_reg  <= 5'h1F;
      level_reg <= 1'b1;
    end else if (bypass) begin
      hist_reg  <= {5{s3_reg}};
      if (s2_reg == s3_reg)
        level_reg <= s3_reg;
    end else if (sample_stb) begin
      hist_reg <= {hist_reg[3:0], s3_reg};
      if (stable)
        level_reg <= s3_reg;
    end
  end
endmodule

// >>> sim/eiq_chk_sva.sv
// Port assertions for the event qualifier and trip block
`timescale 1ns/1ps
module eiq_chk (
  // Clock and reset
  input wire        clk,
  input wire        resetn,
  // Inputs
  input wire [7:0]  qual_period_field,
  input wire [1:0]  power_drive_protect_in,
  input wire [5:0]  compare_trip_in,
  input wire [3:0]  timer_compare_trip_in,
  input wire        soc_req_first,
  input wire        soc_req_second,
  // Outputs
  input wire [15:0] pwm_oe,
  input wire        ev_first_conv_start_out_n,
  input wire        ev_second_conv_start_out_n
);
  wire byp = qual_period_field == 8'h00;
  wire s1 = ev_first_conv_start_out_n;
  wire s2 = ev_second_conv_start_out_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Unqualified low held for seven samples
  sequence s_lo(x);
    byp && $fell(x) ##1 !x [*6];
  endsequence
  a_trip_pair: assert property (s_lo(compare_trip_in[0]) |-> pwm_oe[1:0] == 2'b00)
    else $error("trip left outputs on");
  a_trip_last: assert property (s_lo(compare_trip_in[5]) |-> pwm_oe[11:10] == 2'b00)
    else $error("trip left outputs on");
  a_ttrip_off: assert property (s_lo(timer_compare_trip_in[3]) |-> !pwm_oe[15])
    else $error("timer trip left output on");
  a_prot_off: assert property (s_lo(power_drive_protect_in[0]) |-> ~|pwm_oe[5:0])
    else $error("protect left outputs on");
  a_soc1_low: assert property (soc_req_first |=> !s1)
    else $error("first strobe late");
  a_soc1_hold: assert property ($fell(s1) |-> ##31 !s1)
    else $error("first strobe short");
  a_soc2_low: assert property (soc_req_second |=> !s2)
    else $error("second strobe late");
  a_soc2_hold: assert property ($fell(s2) |-> ##31 !s2)
    else $error("second strobe short");
endmodule

bind eiq_top eiq_chk eiq_chk_i (.clk, .resetn, .qual_period_field, .power_drive_protect_in,
  .compare_trip_in, .timer_compare_trip_in, .soc_req_first, .soc_req_second, .pwm_oe,
  .ev_first_conv_start_out_n, .ev_second_conv_start_out_n);

// >>> sim/eiq_src.sv
// External pin sources and conversion strobe receiver model
`timescale 1ns/1ps
module eiq_src (
  // Clock
  input  wire         clk,
  // Strobes from the block
  input  wire         first_n,
  input  wire         second_n,
  // Pins and measured strobe low widths
  output logic [19:0] pins = '1,
  output int          w1 = 0,
  output int          w2 = 0
);
  int c1 = 0;
  int c2 = 0;
  // Pulse one pin low, never under two cycles
  task automatic low(input int b, input int w);
    @(posedge clk) #1 pins[b] = 1'b0;
    repeat ((w < 2) ? 2 : w) @(posedge clk);
    #1 pins[b] = 1'b1;
  endtask
  always @(posedge clk) begin
    c1 <= first_n ? 0 : c1 + 1;
    c2 <= second_n ? 0 : c2 + 1;
    if (first_n && c1 > 0) w1 <= c1;
    if (second_n && c2 > 0) w2 <= c2;
  end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the event qualifier and trip block
`timescale 1ns/1ps
module tb;
  logic        clk = 0;
  logic        resetn = 0;
  logic [7:0]  qual_period_field = 8'h00;
  logic [1:0]  full_compare_out_enable = 2'b00;
  logic        soc_req_first = 0;
  logic        soc_req_second = 0;
  wire  [19:0] pins;
  wire  [1:0]  timer_dir_q, irq_fetch, capture_q, timer_ext_clk_q;
  wire  [15:0] pwm_oe;
  wire         ev_first_conv_start_out_n, ev_second_conv_start_out_n;
  int          w1, w2, n_mismatch = 0, tests_run = 0, cyc = 0, n_irq = 0;
  always #4 clk = ~clk;
  eiq_src eiq_src_i (.clk, .first_n(ev_first_conv_start_out_n),
    .second_n(ev_second_conv_start_out_n), .pins, .w1, .w2);
  eiq_top eiq_top_i (.clk, .resetn, .qual_period_field, .timer_dir_in(pins[1:0]),
    .capture_in(pins[3:2]), .timer_ext_clk_in(pins[5:4]), .ext_irq_in(pins[7:6]),
    .power_drive_protect_in(pins[9:8]), .compare_trip_in(pins[15:10]),
    .timer_compare_trip_in(pins[19:16]), .full_compare_out_enable, .soc_req_first,
    .soc_req_second, .timer_dir_q, .capture_q, .timer_ext_clk_q, .pwm_oe, .irq_fetch,
    .ev_first_conv_start_out_n, .ev_second_conv_start_out_n);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (irq_fetch[0] === 1'b1) n_irq <= n_irq + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Both strobes, second one restarted while low
  task automatic t_soc();
    {soc_req_first, soc_req_second} = 2'b11;
    wt(1);
    {soc_req_first, soc_req_second} = 2'b00;
    wt(10);
    soc_req_second = 1;
    wt(1);
    soc_req_second = 0;
    wt(40);
    chk(16'(w1), 16'h0020);
    chk(16'(w2), 16'h002B);
    $display("strobes done");
  endtask
  task automatic t_trip();
    logic [15:0] m;
    full_compare_out_enable = 2'b11;
    wt(8);
    for (int i = 0; i < 10; i++) begin
      m = (i < 6) ? 16'h0003 << (2 * i) : 16'h0001 << (6 + i);
      eiq_src_i.low(10 + i, 8);
      chk(pwm_oe & m, 16'h0000);
      wt(8);
      chk(pwm_oe & 16'h0FFF, 16'h0FFF);
    end
    $display("trips done");
  endtask
  task automatic t_prot();
    eiq_src_i.low(8, 8);
    wt(10);
    chk(pwm_oe & 16'h003F, 16'h0000);
    full_compare_out_enable = 2'b00;
    wt(4);
    full_compare_out_enable = 2'b11;
    wt(8);
    chk(pwm_oe & 16'h0FFF, 16'h0FFF);
    $display("protect done");
  endtask
  task automatic t_irq();
    int n0;
    n0 = n_irq;
    eiq_src_i.low(6, 6);
    wt(20);
    chk(16'(n_irq - n0), 16'h0002);
    $display("interrupt done");
  endtask
  // Capture and external timer clock levels reach their outputs
  task automatic t_lvl();
    eiq_src_i.low(2, 8);
    chk(16'(capture_q), 16'h0002);
    repeat (3) begin
      eiq_src_i.low(4, 4);
      wt(3);
    end
    eiq_src_i.low(4, 8);
    chk(16'(timer_ext_clk_q), 16'h0002);
    $display("levels done");
  endtask
  // Glitch ignored, long pulse seen, then level restored
  task automatic t_qual(input int n);
    qual_period_field = 8'(n);
    wt(4);
    eiq_src_i.low(0, 3 * n);
    wt(14 * n + 8);
    chk(16'(timer_dir_q), 16'h0003);
    eiq_src_i.low(0, 12 * n + 12);
    chk(16'(timer_dir_q), 16'h0002);
    wt(14 * n + 8);
    chk(16'(timer_dir_q), 16'h0003);
    $display("qualifier done");
  endtask
  initial begin
    wt(20);
    resetn = 1;
    wt(2);
    t_soc();
    t_trip();
    t_prot();
    t_irq();
    t_lvl();
    t_qual(1);
    t_qual(255);
    results();
  end
endmodule
